// file: include/sram_host_pkg.sv
// Constants for the host side of a 64K x 1 asynchronous static memory.
// Assumes a single core clock whose period is given in picoseconds below.
package sram_host_pkg;

   localparam int ADDR_BITS       = 16;
   localparam int DEPTH           = 65536;
   localparam int CLK_PERIOD_PS   = 10000;

   // Pin timing of the fastest grade, in ns
   localparam int READ_CYCLE_MIN_NS        = 10;
   localparam int WRITE_CYCLE_MIN_NS       = 10;
   localparam int SELECT_TO_DATA_DELAY_NS  = 10;
   localparam int ADDRESS_TO_WRITE_END_NS  = 8;
   localparam int DATA_TO_WRITE_END_NS     = 6;
   localparam int DESELECT_TO_FLOAT_NS     = 5;
   localparam int DESELECT_TO_POWER_DOWN_NS = 10;

   // Least times round up to whole cycles, never below one
   function automatic int min_cycles(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   localparam int ACCESS_CYC  = max2(min_cycles(SELECT_TO_DATA_DELAY_NS),
                                     min_cycles(READ_CYCLE_MIN_NS));
   localparam int WRITE_CYC   = max2(max2(min_cycles(ADDRESS_TO_WRITE_END_NS),
                                          min_cycles(DATA_TO_WRITE_END_NS)),
                                     min_cycles(WRITE_CYCLE_MIN_NS));
   localparam int RECOVER_CYC = min_cycles(DESELECT_TO_FLOAT_NS);

   localparam int TIMER_BITS  = 4;

   localparam logic       PIN_ACTIVE_N   = 1'h0;
   localparam logic       PIN_INACTIVE_N = 1'h1;
   localparam logic [15:0] ADDR_RESET    = 16'h0000;

endpackage

// file: hw/cycle_timer.sv
// Down counter that reports when a loaded cycle count has run out.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module cycle_timer #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   output logic                  done
);

   if (WIDTH < 1)
      $error("WIDTH must be at least one");

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   assign next_count = load ? load_value
                     : (count != '0) ? WIDTH'(count - 1'b1) : count;
   assign done       = (count == '0);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         count <= '0;
      else
         count <= next_count;
   end

endmodule

// file: hw/sram_host.sv
// Host controller that runs single-bit reads and writes on a 64K x 1
// asynchronous static memory through its address, select, strobe and data pins.
// Assumes the memory data output is resolved to a level by the surroundings
// and that user inputs are synchronous to CORE_CLK.
//
// What this block does
// - Read: select low, strobe high, sample output
// - Write: select and strobe low, drive input
// - Address valid by select fall; strobe high there in reads only
// - Read cycle held at least 10 ns
// - Write cycle held at least 10 ns
// - Address stable 8 ns before write end
// - Write data valid 6 ns before end
`timescale 1ns/1ns
module sram_host #(
   parameter int ADDR_WIDTH        = sram_host_pkg::ADDR_BITS,
   parameter int ACCESS_MARGIN_CYC = 1
) (
   input  wire logic                  CORE_CLK,
   input  wire logic                  RST,
   input  wire logic                  REQ,
   input  wire logic                  WR,
   input  wire logic [ADDR_WIDTH-1:0] ADDR,
   input  wire logic                  WDATA,
   output logic                       READY,
   output logic                       RDATA,
   output logic                       RVALID,
   output logic [ADDR_WIDTH-1:0]      SRAM_ADDR,
   output logic                       SRAM_CE_N,
   output logic                       SRAM_WE_N,
   output logic                       SRAM_DIN,
   input  wire logic                  SRAM_DOUT
);

   localparam int TW = sram_host_pkg::TIMER_BITS;
   localparam int READ_HOLD = sram_host_pkg::ACCESS_CYC + ACCESS_MARGIN_CYC;

   // Elaboration checks on the parameters
   if (ADDR_WIDTH != sram_host_pkg::ADDR_BITS)
      $error("ADDR_WIDTH must match the memory address width");
   if (ACCESS_MARGIN_CYC < 0 || READ_HOLD > (1 << TW))
      $error("ACCESS_MARGIN_CYC out of range");
   if (sram_host_pkg::WRITE_CYC > (1 << TW) || sram_host_pkg::RECOVER_CYC > (1 << TW))
      $error("Timer too narrow for the cycle counts");

   typedef enum logic [1:0] {IDLE, READING, WRITING, RECOVER} state_e;

   localparam logic [TW-1:0] READ_LOAD    = TW'(READ_HOLD - 1);
   localparam logic [TW-1:0] WRITE_LOAD   = TW'(sram_host_pkg::WRITE_CYC - 1);
   localparam logic [TW-1:0] RECOVER_LOAD = TW'(sram_host_pkg::RECOVER_CYC - 1);

   state_e          state;
   state_e          next_state;
   logic            timer_done;
   logic            timer_load;
   logic [TW-1:0]   timer_value;

   wire accept    = (state == IDLE) && REQ && READY;
   wire start_rd  = accept && !WR;
   wire start_wr  = accept && WR;
   wire cycle_end = timer_done && (state == READING || state == WRITING);
   wire rec_end   = timer_done && (state == RECOVER);

   assign timer_load  = accept || cycle_end;
   assign timer_value = start_rd ? READ_LOAD
                      : start_wr ? WRITE_LOAD : RECOVER_LOAD;

   always_comb
   begin
      next_state = state;
      unique case (state)
         IDLE:    if (start_rd) next_state = READING;
                  else if (start_wr) next_state = WRITING;
         READING: if (timer_done) next_state = RECOVER;
         WRITING: if (timer_done) next_state = RECOVER;
         RECOVER: if (timer_done) next_state = IDLE;
      endcase
   end

   cycle_timer #(
      .WIDTH      (TW)
   ) u_timer (
      .clk        (CORE_CLK),
      .rst        (RST),
      .load       (timer_load),
      .load_value (timer_value),
      .done       (timer_done)
   );

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         state <= IDLE;
      else
         state <= next_state;
   end

   // Address is driven at request and write data at write request; each held until the next such request
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         SRAM_ADDR <= sram_host_pkg::ADDR_RESET;
         SRAM_DIN  <= 1'h0;
      end
      else if (accept)
      begin
         SRAM_ADDR <= ADDR;
         SRAM_DIN  <= WR ? WDATA : SRAM_DIN;
      end
   end

   // Select falls with the address; select rises at cycle end, and after a write the strobe rises with it
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         SRAM_CE_N <= sram_host_pkg::PIN_INACTIVE_N;
         SRAM_WE_N <= sram_host_pkg::PIN_INACTIVE_N;
      end
      else if (accept)
      begin
         SRAM_CE_N <= sram_host_pkg::PIN_ACTIVE_N;
         SRAM_WE_N <= WR ? sram_host_pkg::PIN_ACTIVE_N
                         : sram_host_pkg::PIN_INACTIVE_N;
      end
      else if (cycle_end)
      begin
         SRAM_CE_N <= sram_host_pkg::PIN_INACTIVE_N;
         SRAM_WE_N <= sram_host_pkg::PIN_INACTIVE_N;
      end
   end

   // Read data is sampled at the last edge of the held read cycle
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         RDATA  <= 1'h0;
         RVALID <= 1'h0;
      end
      else
      begin
         RVALID <= cycle_end && (state == READING);
         if (cycle_end && state == READING)
            RDATA <= SRAM_DOUT;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         READY <= 1'h0;
      else if (accept)
         READY <= 1'h0;
      else if (state == IDLE || rec_end)
         READY <= 1'h1;
   end

endmodule

// file: tb/sram_host_sva.sv
// Pin checks for the static memory controller.
// Bound to sram_host; sees its ports only.
`timescale 1ns/1ns
module sram_host_chk #(parameter int ADDR_WIDTH = 16) (
   input wire logic CORE_CLK, RST, REQ, WR, WDATA, READY, RDATA, RVALID,
   input wire logic [ADDR_WIDTH-1:0] ADDR, SRAM_ADDR,
   input wire logic SRAM_CE_N, SRAM_WE_N, SRAM_DIN, SRAM_DOUT
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   wire acc = REQ && READY;
   a_accept_addr: assert property (acc |=> SRAM_ADDR == $past(ADDR))
      else $error("address not presented");
   a_read_strobe: assert property (acc && !WR |=> SRAM_WE_N && !SRAM_CE_N ##1 SRAM_WE_N)
      else $error("read strobe wrong");
   a_write_start: assert property (acc && WR |=> !SRAM_WE_N && !SRAM_CE_N && SRAM_DIN == $past(WDATA))
      else $error("write start wrong");
   a_write_width: assert property ($fell(SRAM_WE_N) |=> SRAM_WE_N)
      else $error("write strobe width");
   a_rise_together: assert property ($rose(SRAM_WE_N) |-> $rose(SRAM_CE_N))
      else $error("select and strobe apart");
   a_pins_steady: assert property (!SRAM_CE_N && !$past(SRAM_CE_N) |-> $stable(SRAM_ADDR) && $stable(SRAM_DIN))
      else $error("pins moved while selected");
   a_read_sample: assert property ($fell(SRAM_CE_N) && SRAM_WE_N |-> ##1 !SRAM_CE_N ##1 SRAM_CE_N && RVALID)
      else $error("read sample timing");
   a_rdata_source: assert property (RVALID |-> RDATA == $past(SRAM_DOUT))
      else $error("read data not from pin");
   a_rvalid_pulse: assert property (RVALID |=> !RVALID)
      else $error("valid longer than a cycle");
   a_float_wait: assert property ($rose(SRAM_CE_N) |-> !READY ##1 READY)
      else $error("recovery wrong");
   c_write: cover property (acc && WR);
   c_read: cover property (acc && !WR);
   c_valid: cover property (RVALID);
endmodule
bind sram_host sram_host_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.*);

// file: tb/sram_model.sv
// Behavioural 64K x 1 asynchronous static memory.
// Driven by the controller pins; a floating output toggles.
`timescale 1ns/1ns
module sram_model (
   input  wire logic        ce_n,
   input  wire logic        we_n,
   input  wire logic [15:0] addr,
   input  wire logic        din,
   output logic             dout
);
   logic mem [65536];
   wire  wr_on = !ce_n && !we_n;
   initial dout = 1'h0;
   always @(negedge wr_on) mem[addr] = din;
   always @(ce_n, we_n, addr)
   begin
      dout <= #2 ~dout;
      if (!ce_n && we_n) dout <= #10 mem[addr];
   end
endmodule

// file: tb/testbench.sv
// Self-checking bench for sram_host with a memory model on its pins.
// Inputs change on the falling clock edge.
`timescale 1ns/1ns
module testbench;
   logic clk, rst, req, wr, wdata, dout, ready, rdata, rvalid, ce_n, we_n, din;
   logic [15:0] addr, sa, a;
   logic        d;
   int          n_fail, check_count;
   logic        ref_mem [int];
   logic [15:0] q [$];
   sram_host DUT (.CORE_CLK(clk), .RST(rst), .REQ(req), .WR(wr), .ADDR(addr),
      .WDATA(wdata), .READY(ready), .RDATA(rdata), .RVALID(rvalid), .SRAM_ADDR(sa),
      .SRAM_CE_N(ce_n), .SRAM_WE_N(we_n), .SRAM_DIN(din), .SRAM_DOUT(dout));
   sram_model mem (.ce_n(ce_n), .we_n(we_n), .addr(sa), .din(din), .dout(dout));
   task check(input logic seen, input logic exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %b want %b", $time, seen, exp);
      end
   endtask
   task close_out;
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task op(input logic w, input logic [15:0] ad, input logic dt);
      int k;
      k = 0;
      while (ready !== 1'h1 && k < 20)
      begin
         @(negedge clk);
         k++;
      end
      check(ready, 1'h1);
      req = 1'h1;
      wr = w;
      addr = ad;
      wdata = dt;
      @(negedge clk);
      req = 1'h0;
      addr = 16'($urandom);
      wdata = 1'($urandom);
      if (w) ref_mem[ad] = dt;
      else
      begin
         k = 0;
         while (rvalid !== 1'h1 && k < 10)
         begin
            @(negedge clk);
            k++;
         end
         check(rvalid, 1'h1);
         check(rdata, ref_mem[ad]);
      end
   endtask
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #60000;
      n_fail++;
      close_out;
   end
   initial
   begin
      rst = 1'h1;
      req = 1'h0;
      wr = 1'h0;
      addr = 16'h0000;
      wdata = 1'h0;
      void'($urandom(14));
      repeat (5) @(negedge clk);
      rst = 1'h0;
      op(1'h1, 16'h0000, 1'h1);
      op(1'h1, 16'hffff, 1'h0);
      op(1'h0, 16'h0000, 1'h0);
      op(1'h0, 16'hffff, 1'h0);
      repeat (60)
      begin
         a = 16'($urandom);
         d = 1'($urandom);
         q.push_back(a);
         op(1'h1, a, d);
         op(1'h0, a, 1'h0);
         op(1'h1, a, ~d);
      end
      op(1'h1, 16'h0005, 1'h1);
      @(negedge clk);
      req = 1'h1;
      wr = 1'h1;
      addr = 16'h0005;
      wdata = 1'h0;
      @(negedge clk);
      req = 1'h0;
      @(negedge clk);
      op(1'h0, 16'h0005, 1'h0);
      rst = 1'h1;
      @(negedge clk);
      rst = 1'h0;
      repeat (60) op(1'h0, q[$urandom % q.size()], 1'h0);
      close_out;
   end
endmodule
